// file: acpt_pkg.sv
// constants shared by the alarm and control pin timing block
package acpt_pkg;
    // -------------------------------------------------------------
    // clock and timing figures
    // -------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned COOLER_MAX_MS = 100;
    localparam int unsigned INIT_MAX_MS = 2500;
    localparam int unsigned TXOFF_MAX_US = 100;
    localparam int unsigned TXON_MAX_MS = 20;
    localparam int unsigned LOS_MAX_MS = 150;
    localparam int unsigned SRQ_MAX_MS = 150;
    // longest times round down to whole cycles
    localparam int unsigned COOLER_CYC = COOLER_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned INIT_CYC = INIT_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TXOFF_CYC = TXOFF_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned TXON_CYC = TXON_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned LOS_CYC = LOS_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned SRQ_CYC = SRQ_MAX_MS * 1000000 / CLK_PERIOD_NS;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic RST_PIN_HIGH = 1'b1;
    localparam logic RST_PIN_LOW = 1'b0;
    // -------------------------------------------------------------
    // transmitter states
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        ACPT_TX_OFF,
        ACPT_TX_TURN_ON,
        ACPT_TX_ON
    } acpt_tx_state_t;
endpackage

// file: acpt_follow.sv
// delayed follower: output tracks input after a fixed settle count
module acpt_follow #(
    parameter int unsigned DELAY = 4,    // cycles input must hold before output follows
    parameter logic RST_VAL = 1'b0       // output value during reset
) (
    input wire logic clk_sys_i,          // system clock
    input wire logic nrst_i,             // synchronous reset, active low
    input wire logic level_i,            // level to follow
    output logic level_o                 // follower output, registered
);
    localparam int unsigned CW = $clog2(DELAY + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(DELAY - 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic out_q;
    logic out_d;
    wire differ = level_i != out_q;
    wire expire = differ && (cnt_q == CNT_MAX);
    // a glitch shorter than the count restarts it, so output never chatters
    assign cnt_d = (!differ || expire) ? '0 : cnt_q + CW'(1);
    assign out_d = expire ? level_i : out_q;
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            out_q <= RST_VAL;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end
    assign level_o = out_q;
endmodule

// file: acpt_top.sv
// alarm and control pin sequencing for the optical sub-assembly
// Operation
// - cooler pin asserts within 100 ms after the cooler-enable bit sets
// - cooler pin deasserts within 100 ms after the cooler-enable bit clears
// - initialization completes within 2.5 s after reset
// - transmit stops within 100 us of disable; turn-on state within 20 ms
// - pin-state indication asserts within 150 ms of loss-of-signal pin asserting
// - pin-state indication clears within 150 ms of loss-of-signal pin releasing
// - service request asserts within 150 ms of any alarm condition
// - service request held while any condition; released within 150 ms after last
// - transmit-disable input active low; low disables transmit output
// - loss-of-signal pin low when received power below programmed threshold
// - service request high when no fault, low on fault; host reads alarms
// - module-select high blocks two-wire responses; host keeps it steady
module acpt_top #(
    parameter int unsigned COOLER_CYC = acpt_pkg::COOLER_CYC,  // cooler pin latency
    parameter int unsigned INIT_CYC = acpt_pkg::INIT_CYC,      // initialization time
    parameter int unsigned TXOFF_CYC = acpt_pkg::TXOFF_CYC,    // transmit shut-off
    parameter int unsigned TXON_CYC = acpt_pkg::TXON_CYC,      // transmit turn-on
    parameter int unsigned LOS_CYC = acpt_pkg::LOS_CYC,        // loss pin-state latency
    parameter int unsigned SRQ_CYC = acpt_pkg::SRQ_CYC,        // service request latency
    parameter int unsigned PWR_W = 16,                         // received power width
    parameter int unsigned COND_W = 8                          // alarm condition count
) (
    input wire logic clk_sys_i,                 // controller clock 100 MHz
    input wire logic nrst_i,                    // synchronous reset, active low
    input wire logic cooler_enable_bit_i,       // software cooler-enable control bit
    output logic cooler_enable_o,               // cooler-enable pin, high = on
    input wire logic transmit_disable_n_i,      // transmit disable, low = off
    output logic tx_enable_o,                   // laser transmit enable
    output logic tx_turn_on_o,                  // transmitter in turn-on state
    input wire logic [PWR_W-1:0] rx_power_i,    // measured received power
    input wire logic [PWR_W-1:0] los_thresh_i,  // programmed loss threshold
    output logic rx_signal_lost_n_o,            // loss-of-signal pin, low = lost
    output logic los_pin_state_o,               // readable pin state, high = lost
    input wire logic [COND_W-1:0] fault_alarm_warning_status_i, // live conditions
    output logic service_request_n_o,           // service request pin, low = request
    input wire logic module_select_n_i,         // module select, low = selected
    output logic two_wire_enable_o,             // two-wire port may respond
    output logic init_done_o                    // module initialization complete
);
    // -------------------------------------------------------------
    // initialization timer
    // -------------------------------------------------------------
    // init is finished well inside the limit; half the budget leaves margin
    localparam int unsigned INIT_USE = (INIT_CYC / 2 > 0) ? INIT_CYC / 2 : 1;
    localparam int unsigned IW = $clog2(INIT_USE + 1);
    localparam logic [IW-1:0] INIT_LAST = IW'(INIT_USE - 1);
    logic [IW-1:0] init_cnt_q;
    logic init_done_q;
    wire init_end = !init_done_q && (init_cnt_q == INIT_LAST);
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            init_cnt_q <= '0;
            init_done_q <= 1'b0;
        end else begin
            init_cnt_q <= init_done_q ? init_cnt_q : init_cnt_q + IW'(1);
            init_done_q <= init_done_q | init_end;
        end
    end
    assign init_done_o = init_done_q;
    // -------------------------------------------------------------
    // cooler enable pin
    // -------------------------------------------------------------
    // settle count well below the bound rejects a toggling control bit
    acpt_follow #(
        .DELAY(COOLER_CYC / 2 > 0 ? COOLER_CYC / 2 : 1),
        .RST_VAL(acpt_pkg::RST_PIN_LOW)
    ) u_cooler (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .level_i(cooler_enable_bit_i),
        .level_o(cooler_enable_o)
    );
    // -------------------------------------------------------------
    // transmitter control
    // -------------------------------------------------------------
    // shut-off is immediate, well inside its bound; turn-on waits a count
    localparam int unsigned TXON_USE = (TXON_CYC / 2 > 0) ? TXON_CYC / 2 : 1;
    localparam int unsigned TW = $clog2(TXON_USE + 1);
    localparam logic [TW-1:0] TXON_LAST = TW'(TXON_USE - 1);
    acpt_pkg::acpt_tx_state_t tx_st_q;
    acpt_pkg::acpt_tx_state_t tx_st_d;
    logic [TW-1:0] txon_cnt_q;
    wire tx_req = transmit_disable_n_i && init_done_q;
    always_comb begin
        tx_st_d = tx_st_q;
        case (tx_st_q)
            acpt_pkg::ACPT_TX_OFF: begin
                if (tx_req) begin
                    tx_st_d = acpt_pkg::ACPT_TX_TURN_ON;
                end
            end
            acpt_pkg::ACPT_TX_TURN_ON: begin
                if (!tx_req) begin
                    tx_st_d = acpt_pkg::ACPT_TX_OFF;
                end else if (txon_cnt_q == TXON_LAST) begin
                    tx_st_d = acpt_pkg::ACPT_TX_ON;
                end
            end
            acpt_pkg::ACPT_TX_ON: begin
                if (!tx_req) begin
                    tx_st_d = acpt_pkg::ACPT_TX_OFF;
                end
            end
            default: begin
                tx_st_d = acpt_pkg::ACPT_TX_OFF;
            end
        endcase
    end
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tx_st_q <= acpt_pkg::ACPT_TX_OFF;
            txon_cnt_q <= '0;
        end else begin
            tx_st_q <= tx_st_d;
            txon_cnt_q <= (tx_st_q == acpt_pkg::ACPT_TX_TURN_ON) ? txon_cnt_q + TW'(1) : '0;
        end
    end
    // transmit enable is registered from the next state, which sees the live pin, so shut-off takes one edge
    logic tx_en_q;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tx_en_q <= 1'b0;
        end else begin
            tx_en_q <= (tx_st_d == acpt_pkg::ACPT_TX_ON);
        end
    end
    assign tx_enable_o = tx_en_q;
    assign tx_turn_on_o = (tx_st_q == acpt_pkg::ACPT_TX_TURN_ON);
    // -------------------------------------------------------------
    // loss of signal pin and its readable state
    // -------------------------------------------------------------
    logic los_n_q;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            los_n_q <= acpt_pkg::RST_PIN_HIGH;
        end else begin
            los_n_q <= !(rx_power_i < los_thresh_i);
        end
    end
    assign rx_signal_lost_n_o = los_n_q;
    logic los_state_n;
    acpt_follow #(
        .DELAY(LOS_CYC / 2 > 0 ? LOS_CYC / 2 : 1),
        .RST_VAL(acpt_pkg::RST_PIN_HIGH)
    ) u_los (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .level_i(los_n_q),
        .level_o(los_state_n)
    );
    assign los_pin_state_o = !los_state_n;
    // -------------------------------------------------------------
    // service request
    // -------------------------------------------------------------
    // no ready pulse on this pin: init_done_o carries readiness; a host read clears nothing
    wire any_cond = |fault_alarm_warning_status_i;
    logic srq_n;
    acpt_follow #(
        .DELAY(SRQ_CYC / 2 > 0 ? SRQ_CYC / 2 : 1),
        .RST_VAL(acpt_pkg::RST_PIN_HIGH)
    ) u_srq (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .level_i(!any_cond),
        .level_o(srq_n)
    );
    assign service_request_n_o = srq_n;
    // -------------------------------------------------------------
    // two-wire gating
    // -------------------------------------------------------------
    assign two_wire_enable_o = !module_select_n_i && init_done_q;
    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    int unsigned srq_age_q;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || !any_cond || !srq_n) begin
            srq_age_q <= 0;
        end else begin
            srq_age_q <= srq_age_q + 1;
        end
    end
    property p_srq_bound;
        @(posedge clk_sys_i) disable iff (!nrst_i) srq_age_q <= SRQ_CYC;
    endproperty
    a_srq_bound: assert property (p_srq_bound) else $error("service request late");
    property p_tx_off;
        @(posedge clk_sys_i) disable iff (!nrst_i) !transmit_disable_n_i |=> !tx_enable_o;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("transmit not shut off");
    property p_los_pin;
        @(posedge clk_sys_i) disable iff (!nrst_i)
            (rx_power_i < los_thresh_i) |=> !rx_signal_lost_n_o;
    endproperty
    a_los_pin: assert property (p_los_pin) else $error("loss pin not low");
    property p_twi;
        @(posedge clk_sys_i) disable iff (!nrst_i) module_select_n_i |-> !two_wire_enable_o;
    endproperty
    a_twi: assert property (p_twi) else $error("two-wire enabled while deselected");
    property p_srq_hold;
        @(posedge clk_sys_i) disable iff (!nrst_i)
            (!service_request_n_o && any_cond) |=> !service_request_n_o;
    endproperty
    a_srq_hold: assert property (p_srq_hold) else $error("request released early");
    property p_init;
        @(posedge clk_sys_i) disable iff (!nrst_i)
            $rose(init_done_o) |-> $past(init_cnt_q) == INIT_LAST;
    endproperty
    a_init: assert property (p_init) else $error("init done at wrong count");
    // cooler pin may lag its control bit, but never past the bound
    int unsigned cool_age_q;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || (cooler_enable_bit_i == cooler_enable_o)) begin
            cool_age_q <= 0;
        end else begin
            cool_age_q <= cool_age_q + 1;
        end
    end
    property p_cooler_bound;
        @(posedge clk_sys_i) disable iff (!nrst_i) cool_age_q <= COOLER_CYC;
    endproperty
    a_cooler_bound: assert property (p_cooler_bound) else $error("cooler pin late");
    // released and idle transmitter must show the turn-on state one edge later
    sequence s_tx_released;
        transmit_disable_n_i && init_done_o && !tx_turn_on_o && !tx_enable_o;
    endsequence
    sequence s_tx_turning;
        tx_turn_on_o && !tx_enable_o;
    endsequence
    property p_tx_turn_on;
        @(posedge clk_sys_i) disable iff (!nrst_i) s_tx_released |=> s_tx_turning;
    endproperty
    a_tx_turn_on: assert property (p_tx_turn_on) else $error("turn-on state late");
endmodule

// file: acpt_host_model.sv
// host controller model for the control pins of the alarm and control block
module acpt_host_model (
    input wire logic clk_sys_i,        // controller clock
    input wire logic tx_off_req_i,     // bench asks for transmit shut-off
    input wire logic sel_req_i,        // bench asks to select the module
    output logic transmit_disable_n_o, // transmit disable pin, low = off
    output logic module_select_n_o     // module select pin, low = selected
);
    timeunit 1ns;
    timeprecision 100ps;
    // -------------------------------------------------------------
    // pin drivers
    // -------------------------------------------------------------
    // pins start at their resistor levels: disable pulled low, select pulled high
    logic tdis_n_q = 1'b0;
    logic msel_n_q = 1'b1;
    // select only moves on request and no two-wire traffic runs, so it never
    // changes inside a transaction
    always @(posedge clk_sys_i) begin
        tdis_n_q <= #1 !tx_off_req_i;
        msel_n_q <= #1 !sel_req_i;
    end
    assign transmit_disable_n_o = tdis_n_q;
    assign module_select_n_o = msel_n_q;
endmodule

// file: acpt_top_tb_top.sv
// self-checking testbench for the alarm and control pin timing block
module acpt_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned TC = 20; // shortened count for every latency
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cool_bit = 1'b0;
    logic tx_off_req = 1'b1;
    logic sel_req = 1'b0;
    logic [15:0] pwr = 16'h0100;
    logic [15:0] thr = 16'h0080;
    logic [7:0] alarm_bits = 8'h00;
    logic tdis_n, msel_n, cool_o, txen, txon, los_n, los_st, srq_n, tw_en, init_o;
    int errors = 0;
    int n_checks = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    // -------------------------------------------------------------
    // design and host model
    // -------------------------------------------------------------
    acpt_top #(.COOLER_CYC(TC), .INIT_CYC(TC), .TXOFF_CYC(TC), .TXON_CYC(TC),
        .LOS_CYC(TC), .SRQ_CYC(TC)) u_acpt_top (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cooler_enable_bit_i(cool_bit),
        .cooler_enable_o(cool_o), .transmit_disable_n_i(tdis_n), .tx_enable_o(txen),
        .tx_turn_on_o(txon), .rx_power_i(pwr), .los_thresh_i(thr),
        .rx_signal_lost_n_o(los_n), .los_pin_state_o(los_st),
        .fault_alarm_warning_status_i(alarm_bits), .service_request_n_o(srq_n),
        .module_select_n_i(msel_n), .two_wire_enable_o(tw_en), .init_done_o(init_o));
    acpt_host_model u_acpt_host_model (.clk_sys_i(clk_sys_i), .tx_off_req_i(tx_off_req),
        .sel_req_i(sel_req), .transmit_disable_n_o(tdis_n), .module_select_n_o(msel_n));
    // -------------------------------------------------------------
    // shared helpers
    // -------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    // reset levels, then init completion and module select gating
    task automatic t_init;
        check("reset pins", {cool_o, txen, txon, los_n, los_st, srq_n, tw_en, init_o},
            8'h14);
        step(4);
        check("init early", {7'h00, init_o}, 8'h00);
        step(TC - 4);
        check("init done", {7'h00, init_o}, 8'h01);
        check("twi unselected", {7'h00, tw_en}, 8'h00);
        sel_req = 1'b1;
        step(3);
        check("twi selected", {7'h00, tw_en}, 8'h01);
        sel_req = 1'b0;
        step(3);
        check("twi released", {7'h00, tw_en}, 8'h00);
    endtask
    // cooler pin ignores a short pulse, then follows both edges in time
    task automatic t_cooler;
        cool_bit = 1'b1;
        step(3);
        cool_bit = 1'b0;
        step(TC);
        check("cooler glitch", {7'h00, cool_o}, 8'h00);
        cool_bit = 1'b1;
        step(TC);
        check("cooler on", {7'h00, cool_o}, 8'h01);
        cool_bit = 1'b0;
        step(TC);
        check("cooler off", {7'h00, cool_o}, 8'h00);
    endtask
    // transmit turn-on sequence and fast shut-off
    task automatic t_tx;
        check("tx held off", {6'h00, txen, txon}, 8'h00);
        tx_off_req = 1'b0;
        step(4);
        check("tx turning on", {6'h00, txen, txon}, 8'h01);
        step(TC);
        check("tx on", {6'h00, txen, txon}, 8'h02);
        tx_off_req = 1'b1;
        step(3);
        check("tx shut off", {6'h00, txen, txon}, 8'h00);
    endtask
    // loss pin at the threshold boundary and its readable state
    task automatic t_los;
        pwr = thr;
        step(3);
        check("los at threshold", {7'h00, los_n}, 8'h01);
        pwr = thr - 16'h0001;
        step(3);
        check("los pin", {7'h00, los_n}, 8'h00);
        step(TC);
        check("los state set", {7'h00, los_st}, 8'h01);
        pwr = thr;
        step(TC + 2);
        check("los cleared", {6'h00, los_n, los_st}, 8'h02);
    endtask
    // each condition raises the request; overlap holds it until the last clears
    task automatic t_srq;
        for (int i = 0; i < 8; i++) begin
            alarm_bits = 8'h01 << i;
            step(TC);
            check("srq set", {7'h00, srq_n}, 8'h00);
            alarm_bits = 8'h00;
            step(TC);
            check("srq release", {7'h00, srq_n}, 8'h01);
        end
        alarm_bits = 8'h81;
        step(TC);
        alarm_bits = 8'h80;
        step(TC);
        check("srq held", {7'h00, srq_n}, 8'h00);
        alarm_bits = 8'h00;
        step(TC);
        check("srq idle", {7'h00, srq_n}, 8'h01);
    endtask
    // -------------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------------
    initial begin
        step(12);
        nrst_i = 1'b1;
        t_init();
        t_cooler();
        t_tx();
        t_los();
        t_srq();
        test_done();
    end
    // whole run needs under 1000 cycles; allow ten times that
    initial begin
        #100us;
        errors++;
        test_done();
    end
endmodule
